// ===== ocp_load_model.sv
// Load on the compare pin: counts high cycles and rising edges
module ocp_load_model (
   input  wire logic        mclk,
   input  wire logic        clr,
   input  wire logic        pin,
   output logic      [15:0] highCnt,
   output logic      [15:0] riseCnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pin_q;

   // Window counters, restarted while clr is high
   always_ff @(posedge mclk) begin
      pin_q <= pin;
      if (clr) begin
         highCnt <= 16'h0000;
         riseCnt <= 16'h0000;
      end else begin
         highCnt <= highCnt + 16'(pin);
         riseCnt <= riseCnt + 16'(pin && !pin_q);
      end
   end
endmodule // ocp_load_model

// ===== ocp_map.svh
// Register offsets, field positions and reset values of the compare channel
`ifndef OCP_MAP_SVH
`define OCP_MAP_SVH

// Byte offsets on the register bus
`define OCP_ADDR_CONTROL   5'h00
`define OCP_ADDR_PRIMARY   5'h04
`define OCP_ADDR_SECONDARY 5'h08
`define OCP_ADDR_PERIOD2   5'h0c
`define OCP_ADDR_PERIOD3   5'h10
`define OCP_ADDR_TIMERCTL  5'h14
`define OCP_ADDR_COUNT     5'h18
`define OCP_ADDR_STATUS    5'h1c

// Control word fields
`define OCP_MODE_LSB       0
`define OCP_MODE_MSB       2
`define OCP_TBSEL_BIT      3
`define OCP_FAULT_BIT      4
`define OCP_IDLE_BIT       13

// Timer control and status fields
`define OCP_RUN2_BIT       0
`define OCP_RUN3_BIT       1
`define OCP_IFLAG_BIT      0

// Reset values and the counter increment
`define OCP_RST_WORD       16'h0000
`define OCP_COUNT_ZERO     16'h0000
`define OCP_COUNT_ONE      16'h0001

// Channels allowed to request DMA, and fault input grouping
`define OCP_DMA_LAST_CH    2
`define OCP_FAULTA_LAST_CH 4

`endif

// ===== ocp_output_compare.sv
// One output compare channel with its two time bases and register slave
`include "ocp_map.svh"

// Timing in short: a match is seen on the count of one cycle and shows
// on the pin at the following edge, so the pin lags the count by one.
// The bus answers every access after exactly one wait cycle.
// Duty values pass through the secondary register and reach the compare
// only at a period match, which keeps each PWM period whole.
// The timers are built in with no prescaler; idle halt freezes the
// compare logic but lets the counts run on.

module ocp_output_compare #(
   parameter int CHANNEL = 1
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic        cpuIdle,
   input  wire logic        faultInputAN,
   input  wire logic        faultInputBN,
   output logic             compareOutputPin,
   output logic             compareInterruptFlag,
   output logic             dmaRequest
);

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] mergeHalf(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  be);
      mergeHalf = {be[1] ? data[15:8] : old[15:8],
                   be[0] ? data[7:0]  : old[7:0]};
   endfunction

   // Single and continuous modes share the pulse sequencer
   function automatic logic isPulse(input logic [2:0] m);
      isPulse = (m == ocp_pkg::OCP_SINGLE) ||
                (m == ocp_pkg::OCP_CONTINUOUS);
   endfunction

   // Both duty-cycle modes lock the primary register
   function automatic logic isPwm(input logic [2:0] m);
      isPwm = (m == ocp_pkg::OCP_PWM) || (m == ocp_pkg::OCP_PWM_FAULT);
   endfunction

   ocp_pkg::ocp_ctrl_t  ctrl_q;
   ocp_pkg::ocp_pulse_t pulse_q;
   logic      [15:0] primary_q;
   logic      [15:0] secondary_q;
   logic      [15:0] period2_q;
   logic      [15:0] period3_q;
   logic      [15:0] count2_q;
   logic      [15:0] count3_q;
   logic             run2_q;
   logic             run3_q;
   logic             faultFlag_q;
   logic      [1:0]  faultASync_q;
   logic      [1:0]  faultBSync_q;
   logic      [1:0]  idleSync_q;
   logic             waitReq_q;
   logic      [31:0] readData_q;
   logic             pin_q;
   logic             iflag_q;
   logic             dma_q;

   logic             wrAck;
   logic             wrCtrl;
   logic             wrStatus;
   logic      [15:0] count;
   logic      [15:0] period;
   logic             active;
   logic             priMatch;
   logic             secMatch;
   logic             perMatch;
   logic             pwmMode;
   logic             faultIn;
   logic             faultHit;
   logic             cmpEvent;
   logic             modeWr;
   logic      [2:0]  newMode;

   // Two-stage synchronisers for pins
   // Fault pins idle high, so they reset to their idle level
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         faultASync_q <= 2'h3;
         faultBSync_q <= 2'h3;
         idleSync_q   <= 2'h0;
      end else begin
         faultASync_q <= {faultASync_q[0], faultInputAN};
         faultBSync_q <= {faultBSync_q[0], faultInputBN};
         idleSync_q   <= {idleSync_q[0], cpuIdle};
      end
   end

   // Bus decode and time base selection
   assign wrAck    = write && !waitReq_q;
   assign wrCtrl   = wrAck && (address == `OCP_ADDR_CONTROL);
   assign wrStatus = wrAck && (address == `OCP_ADDR_STATUS);
   assign modeWr   = wrCtrl && byteenable[0];
   // Mode field as it is being written
   assign newMode  = writedata[`OCP_MODE_MSB:`OCP_MODE_LSB];
   assign count    = ctrl_q.timeBaseSelect ? count3_q : count2_q;
   assign period   = ctrl_q.timeBaseSelect ? period3_q : period2_q;
   assign active   = (ctrl_q.timeBaseSelect ? run3_q : run2_q) &&
                     !(ctrl_q.idleHalt && idleSync_q[1]);
   assign priMatch = active && (count == primary_q);
   assign secMatch = active && (count == secondary_q);
   assign perMatch = active && (count == period);
   assign pwmMode  = isPwm(ctrl_q.compareModeSelect);
   assign faultIn  = (CHANNEL <= `OCP_FAULTA_LAST_CH) ?
                     !faultASync_q[1] : !faultBSync_q[1];
   assign faultHit = (ctrl_q.compareModeSelect ==
                      ocp_pkg::OCP_PWM_FAULT) &&
                     faultIn && !faultFlag_q;

   // Bus handshake: one wait cycle, then acknowledge
   // Read data is ready in the acknowledge cycle, so no extra stall
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         waitReq_q <= 1'b1;
      end else begin
         waitReq_q <= !((read || write) && waitReq_q);
      end
   end

   // Read data captured as the acknowledge is given
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         readData_q <= 32'h0000_0000;
      end else if (read && waitReq_q) begin
         unique case (address)
            `OCP_ADDR_CONTROL:   readData_q <= {16'h0000,
               2'h0, ctrl_q.idleHalt, 8'h00, faultFlag_q,
               ctrl_q.timeBaseSelect, ctrl_q.compareModeSelect};
            `OCP_ADDR_PRIMARY:   readData_q <= {16'h0000, primary_q};
            `OCP_ADDR_SECONDARY: readData_q <= {16'h0000, secondary_q};
            `OCP_ADDR_PERIOD2:   readData_q <= {16'h0000, period2_q};
            `OCP_ADDR_PERIOD3:   readData_q <= {16'h0000, period3_q};
            `OCP_ADDR_TIMERCTL:  readData_q <= {30'h0, run3_q, run2_q};
            `OCP_ADDR_COUNT:     readData_q <= {16'h0000, count};
            `OCP_ADDR_STATUS:    readData_q <= {31'h0, iflag_q};
            default:             readData_q <= 32'h0000_0000;
         endcase
      end
   end

   // Control word
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= '0;
      end else if (wrCtrl) begin
         if (byteenable[1])
            ctrl_q.idleHalt <= writedata[`OCP_IDLE_BIT];
         if (byteenable[0]) begin
            ctrl_q.timeBaseSelect <= writedata[`OCP_TBSEL_BIT];
            ctrl_q.compareModeSelect <= ocp_pkg::ocp_mode_t'(newMode);
         end
      end
   end

   // Fault status: set by hardware, cleared by mode rewrite
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         faultFlag_q <= 1'b0;
      end else if (faultHit) begin
         faultFlag_q <= 1'b1;
      end else if (modeWr) begin
         faultFlag_q <= 1'b0;
      end
   end

   // Compare values and duty double buffer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         primary_q   <= `OCP_RST_WORD;
         secondary_q <= `OCP_RST_WORD;
      end else begin
         if (wrAck && address == `OCP_ADDR_SECONDARY)
            secondary_q <= mergeHalf(secondary_q, writedata, byteenable);
         if (pwmMode && perMatch)
            primary_q <= secondary_q;
         else if (!pwmMode && wrAck && address == `OCP_ADDR_PRIMARY)
            primary_q <= mergeHalf(primary_q, writedata, byteenable);
      end
   end

   // Periods and run bits
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         period2_q <= `OCP_RST_WORD;
         period3_q <= `OCP_RST_WORD;
         run2_q    <= 1'b0;
         run3_q    <= 1'b0;
      end else if (wrAck) begin
         if (address == `OCP_ADDR_PERIOD2)
            period2_q <= mergeHalf(period2_q, writedata, byteenable);
         if (address == `OCP_ADDR_PERIOD3)
            period3_q <= mergeHalf(period3_q, writedata, byteenable);
         if (address == `OCP_ADDR_TIMERCTL && byteenable[0]) begin
            run2_q <= writedata[`OCP_RUN2_BIT];
            run3_q <= writedata[`OCP_RUN3_BIT];
         end
      end
   end

   // Time base counters
   // Counts run in every mode, so modes may change on the fly
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count2_q <= `OCP_COUNT_ZERO;
         count3_q <= `OCP_COUNT_ZERO;
      end else begin
         if (run2_q)
            count2_q <= (count2_q == period2_q) ? `OCP_COUNT_ZERO :
                        count2_q + `OCP_COUNT_ONE;
         if (run3_q)
            count3_q <= (count3_q == period3_q) ? `OCP_COUNT_ZERO :
                        count3_q + `OCP_COUNT_ONE;
      end
   end

   // Pulse sequencer for single and continuous modes
   // A mode write re-arms it, so a new single pulse needs only a rewrite
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pulse_q <= ocp_pkg::OCP_P_IDLE;
      end else if (modeWr) begin
         pulse_q <= isPulse(newMode) ? ocp_pkg::OCP_P_RISE :
                                       ocp_pkg::OCP_P_IDLE;
      end else begin
         unique case (pulse_q)
            // Disabled or spent: wait for the next mode write
            ocp_pkg::OCP_P_IDLE: pulse_q <= ocp_pkg::OCP_P_IDLE;
            ocp_pkg::OCP_P_RISE: if (priMatch) begin
               pulse_q <= ocp_pkg::OCP_P_FALL;
            end
            ocp_pkg::OCP_P_FALL: if (secMatch) begin
               pulse_q <= (ctrl_q.compareModeSelect ==
                           ocp_pkg::OCP_CONTINUOUS) ?
                          ocp_pkg::OCP_P_RISE : ocp_pkg::OCP_P_IDLE;
            end
            default: pulse_q <= ocp_pkg::OCP_P_IDLE;
         endcase
      end
   end

   // Output pin
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_q <= 1'b0;
      end else if (modeWr) begin
         // initial pin level
         // Toggle mode keeps whatever level the pin has
         if (newMode == ocp_pkg::OCP_SET_LOW)
            pin_q <= 1'b1;
         else if (newMode != ocp_pkg::OCP_TOGGLE)
            pin_q <= 1'b0;
      end else begin
         unique case (ctrl_q.compareModeSelect)
            ocp_pkg::OCP_OFF:      pin_q <= 1'b0;
            ocp_pkg::OCP_SET_HIGH: if (priMatch) pin_q <= 1'b1;
            ocp_pkg::OCP_SET_LOW:  if (priMatch) pin_q <= 1'b0;
            ocp_pkg::OCP_TOGGLE:   if (priMatch) pin_q <= !pin_q;
            ocp_pkg::OCP_SINGLE, ocp_pkg::OCP_CONTINUOUS: begin
               if (pulse_q == ocp_pkg::OCP_P_RISE && priMatch)
                  pin_q <= 1'b1;
               else if (pulse_q == ocp_pkg::OCP_P_FALL && secMatch)
                  pin_q <= 1'b0;
            end
            ocp_pkg::OCP_PWM, ocp_pkg::OCP_PWM_FAULT: begin
               // fault forces pin low
               // The latch holds it low until the mode is rewritten
               if (faultHit || faultFlag_q)
                  pin_q <= 1'b0;
               else if (active)
                  pin_q <= (count < primary_q);
            end
         endcase
      end
   end

   // Compare events raise the interrupt flag
   // Set, clear and toggle modes count primary matches as events
   always_comb begin
      unique case (ctrl_q.compareModeSelect)
         ocp_pkg::OCP_SET_HIGH, ocp_pkg::OCP_SET_LOW,
         ocp_pkg::OCP_TOGGLE: cmpEvent = priMatch;
         ocp_pkg::OCP_SINGLE, ocp_pkg::OCP_CONTINUOUS:
            cmpEvent = (pulse_q == ocp_pkg::OCP_P_FALL) && secMatch;
         ocp_pkg::OCP_PWM_FAULT: cmpEvent = faultHit;
         default: cmpEvent = 1'b0;
      endcase
   end

   // Interrupt flag: write one to clear, set wins
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         iflag_q <= 1'b0;
      end else if (cmpEvent) begin
         iflag_q <= 1'b1;
      end else if (wrStatus && byteenable[0] &&
                   writedata[`OCP_IFLAG_BIT]) begin
         iflag_q <= 1'b0;
      end
   end

   // DMA request pulse on compare event, for channels up to OCP_DMA_LAST_CH only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dma_q <= 1'b0;
      end else begin
         dma_q <= cmpEvent && (CHANNEL <= `OCP_DMA_LAST_CH);
      end
   end

   assign readdata             = readData_q;
   assign waitrequest          = waitReq_q;
   assign compareOutputPin     = pin_q;
   assign compareInterruptFlag = iflag_q;
   assign dmaRequest           = dma_q;

endmodule // ocp_output_compare

// ===== ocp_output_compare_checker.sv
// Port-level assertions for the output compare channel
`include "ocp_map.svh"

module ocp_output_compare_checker #(
   parameter int CHANNEL = 1
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [4:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        cpuIdle,
   input wire logic        faultInputAN,
   input wire logic        faultInputBN,
   input wire logic        compareOutputPin,
   input wire logic        compareInterruptFlag,
   input wire logic        dmaRequest
);
   logic       ctlWr;
   logic       ctlRd;
   logic       fltN;
   logic [2:0] mode_q;
   logic [2:0] fltCnt_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Acknowledged control accesses and the fault pin of this channel
   assign ctlWr = write && !waitrequest && address == `OCP_ADDR_CONTROL
                  && byteenable[0];
   assign ctlRd = read && !waitrequest && address == `OCP_ADDR_CONTROL;
   assign fltN  = (CHANNEL <= `OCP_FAULTA_LAST_CH) ? faultInputAN
                                                   : faultInputBN;

   // Shadow of the mode field
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_q <= 3'h0;
      end else if (ctlWr) begin
         mode_q <= writedata[2:0];
      end
   end

   // Consecutive cycles of active fault since the last control write, saturating
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fltCnt_q <= 3'h0;
      end else if (ctlWr || fltN) begin
         fltCnt_q <= 3'h0;
      end else if (fltCnt_q != 3'h7) begin
         fltCnt_q <= fltCnt_q + 3'h1;
      end
   end

   AST_DMA_NONE: assert property (
      CHANNEL > `OCP_DMA_LAST_CH |-> !dmaRequest)
      else $error("dma request from a channel without dma");
   AST_DMA_PULSE: assert property (
      dmaRequest |=> !dmaRequest)
      else $error("dma request longer than one cycle");
   AST_CTL_RSVD: assert property (
      ctlRd |-> readdata[15:14] == 2'h0 && readdata[12:5] == 8'h00)
      else $error("reserved control bits read nonzero");
   AST_FAULT_BIT: assert property (
      ctlRd && mode_q == 3'h7 && fltCnt_q == 3'h7
      |-> readdata[`OCP_FAULT_BIT])
      else $error("fault status not set during fault");
   AST_FAULT_PIN: assert property (
      mode_q == 3'h7 && fltCnt_q == 3'h7 |-> !compareOutputPin)
      else $error("pin high during fault");
   AST_CONT_FLAG: assert property (
      $rose(compareInterruptFlag) && mode_q == 3'h5 |-> !compareOutputPin)
      else $error("flag raised with pin still high");
   AST_CONT_DMA: assert property (
      CHANNEL <= `OCP_DMA_LAST_CH && mode_q == 3'h5
      && $past(mode_q, 2) == 3'h5 && $fell(compareOutputPin) |-> dmaRequest)
      else $error("trailing edge without dma request");
   AST_MODE5_LOW: assert property (
      ctlWr && writedata[2:1] == 2'b10 |-> ##[1:2] !compareOutputPin)
      else $error("pin not forced low by pulse mode write");

   // Main scenarios reached
   CVR_FLAG: cover property ($rose(compareInterruptFlag));
   CVR_FAULT: cover property (mode_q == 3'h7 && fltCnt_q == 3'h7);
   CVR_DMA: cover property ($fell(compareOutputPin) && dmaRequest);
endmodule // ocp_output_compare_checker

bind ocp_output_compare ocp_output_compare_checker #(.CHANNEL(CHANNEL)) u_chk (
   .mclk, .rst, .address, .read, .write, .byteenable, .writedata,
   .readdata, .waitrequest, .cpuIdle, .faultInputAN, .faultInputBN,
   .compareOutputPin, .compareInterruptFlag, .dmaRequest);

// ===== ocp_output_compare_tb.sv
// Self-checking bench for the output compare channel
`include "ocp_map.svh"

module ocp_output_compare_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  address = 5'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [3:0]  byteenable = 4'h3;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        cpuIdle = 1'b0;
   logic        fltAN = 1'b1;
   logic        clr = 1'b1;
   logic        pin;
   logic        pin5;
   logic [15:0] highCnt;
   logic [15:0] riseCnt;
   logic [15:0] high5;
   logic [15:0] rd;
   int          error_cnt = 0;
   int          n_tests = 0;

   // Channel one and channel five on one bus
   ocp_output_compare #(.CHANNEL(1)) dut (
      .mclk, .rst, .address, .read, .write, .byteenable, .writedata,
      .readdata, .waitrequest, .cpuIdle, .faultInputAN(fltAN),
      .faultInputBN(1'b1), .compareOutputPin(pin),
      .compareInterruptFlag(), .dmaRequest());
   ocp_output_compare #(.CHANNEL(5)) dut5 (
      .mclk, .rst, .address, .read, .write, .byteenable, .writedata,
      .readdata(), .waitrequest(), .cpuIdle, .faultInputAN(fltAN),
      .faultInputBN(1'b1), .compareOutputPin(pin5),
      .compareInterruptFlag(), .dmaRequest());
   ocp_load_model ld (.mclk, .clr, .pin, .highCnt, .riseCnt);
   ocp_load_model ld5 (.mclk, .clr, .pin(pin5), .highCnt(high5),
                       .riseCnt());

   // Clock generator
   always #12.5 mclk = ~mclk;

   task automatic print_verdict();
      $display("Compares %0d, errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One bus transfer, held until waitrequest is seen low
   task automatic xfer(input logic wr, input logic [4:0] a,
                       input logic [15:0] d);
      address <= a;
      writedata <= {16'h0000, d};
      write <= wr;
      read <= !wr;
      do begin
         @(posedge mclk);
      end while (waitrequest !== 1'b0);
      rd = readdata[15:0];
      write <= 1'b0;
      read <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rc(input logic [4:0] a, input logic [15:0] exp);
      xfer(1'b0, a, 16'h0000);
      chk(rd, exp);
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Mode change with the timers stopped, then the run bits written from run
   task automatic setMode(input logic [15:0] c, input logic [15:0] run);
      wr(`OCP_ADDR_TIMERCTL, 16'h0000);
      wr(`OCP_ADDR_CONTROL, c);
      wr(`OCP_ADDR_TIMERCTL, run);
   endtask

   // Count n pin samples in the load models
   task automatic window(input int n);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      idle(n + 1);
   endtask

   // Watchdog
   initial begin
      idle(20000);
      error_cnt++;
      print_verdict();
   end

   // Test sequence
   initial begin
      logic [15:0] dut_tab [3];
      logic [15:0] exp_tab [3];
      dut_tab = '{16'h0000, 16'h0013, 16'h0015};
      exp_tab = '{16'h0000, 16'h0026, 16'h0028};
      idle(12);
      rst <= 1'b0;
      @(posedge mclk);
      rc(`OCP_ADDR_CONTROL, 16'h0000);
      rc(`OCP_ADDR_STATUS, 16'h0000);
      // PWM with double-buffered duty
      wr(`OCP_ADDR_PERIOD2, 16'h0013);
      wr(`OCP_ADDR_PRIMARY, 16'h0003);
      wr(`OCP_ADDR_SECONDARY, 16'h0005);
      wr(`OCP_ADDR_CONTROL, 16'h0006);
      wr(`OCP_ADDR_PRIMARY, 16'h0001);
      rc(`OCP_ADDR_PRIMARY, 16'h0003);
      wr(`OCP_ADDR_TIMERCTL, 16'h0001);
      idle(24);
      rc(`OCP_ADDR_PRIMARY, 16'h0005);
      window(40);
      chk(highCnt, 16'h000a);
      for (int i = 0; i < 3; i++) begin
         wr(`OCP_ADDR_SECONDARY, dut_tab[i]);
         idle(24);
         window(40);
         chk(highCnt, exp_tab[i]);
      end
      // Fault pin honoured, then ignored
      wr(`OCP_ADDR_SECONDARY, 16'h0005);
      idle(24);
      setMode(16'h0007, 16'h0001);
      wr(`OCP_ADDR_STATUS, 16'h0001);
      fltAN <= 1'b0;
      idle(8);
      window(20);
      chk(highCnt, 16'h0000);
      chk(high5, 16'h0005);
      rc(`OCP_ADDR_STATUS, 16'h0001);
      fltAN <= 1'b1;
      rc(`OCP_ADDR_CONTROL, 16'h0017);
      setMode(16'h0006, 16'h0001);
      fltAN <= 1'b0;
      rc(`OCP_ADDR_CONTROL, 16'h0006);
      idle(8);
      window(40);
      chk(highCnt, 16'h000a);
      fltAN <= 1'b1;
      // Single pulse on the second timer
      setMode(16'h0000, 16'h0000);
      wr(`OCP_ADDR_PRIMARY, 16'h0003);
      wr(`OCP_ADDR_SECONDARY, 16'h0008);
      wr(`OCP_ADDR_STATUS, 16'h0001);
      setMode(16'h0004, 16'h0001);
      window(60);
      chk(riseCnt, 16'h0001);
      chk(highCnt, 16'h0005);
      rc(`OCP_ADDR_STATUS, 16'h0001);
      // Continuous pulses on the third timer
      wr(`OCP_ADDR_PERIOD3, 16'h0009);
      wr(`OCP_ADDR_PRIMARY, 16'h0002);
      wr(`OCP_ADDR_SECONDARY, 16'h0005);
      setMode(16'h000d, 16'h0003);
      idle(20);
      window(40);
      chk(riseCnt, 16'h0004);
      chk(highCnt, 16'h000c);
      wr(`OCP_ADDR_STATUS, 16'h0001);
      idle(12);
      rc(`OCP_ADDR_STATUS, 16'h0001);
      rc(5'h02, 16'h0000);
      // Toggle, then set-low and set-high modes
      setMode(16'h0003, 16'h0001);
      idle(20);
      window(80);
      chk(highCnt, 16'h0028);
      setMode(16'h0002, 16'h0000);
      idle(4);
      chk(16'(pin), 16'h0001);
      wr(`OCP_ADDR_TIMERCTL, 16'h0001);
      idle(24);
      chk(16'(pin), 16'h0000);
      setMode(16'h0001, 16'h0000);
      idle(4);
      chk(16'(pin), 16'h0000);
      wr(`OCP_ADDR_TIMERCTL, 16'h0001);
      idle(24);
      chk(16'(pin), 16'h0001);
      // Idle halt on and off while the core idles
      for (int i = 0; i < 2; i++) begin
         cpuIdle <= 1'b1;
         setMode(i == 0 ? 16'h2005 : 16'h0005, 16'h0001);
         idle(8);
         window(40);
         chk(riseCnt, i == 0 ? 16'h0000 : 16'h0002);
      end
      cpuIdle <= 1'b0;
      print_verdict();
   end
endmodule // ocp_output_compare_tb

// ===== ocp_pkg.sv
// Types shared by the output compare channel
package ocp_pkg;

   // Compare mode codes
   typedef enum logic [2:0] {
      OCP_OFF        = 3'h0,
      OCP_SET_HIGH   = 3'h1,
      OCP_SET_LOW    = 3'h2,
      OCP_TOGGLE     = 3'h3,
      OCP_SINGLE     = 3'h4,
      OCP_CONTINUOUS = 3'h5,
      OCP_PWM        = 3'h6,
      OCP_PWM_FAULT  = 3'h7
   } ocp_mode_t;

   // Software-written control fields
   typedef struct packed {
      logic      idleHalt;
      logic      timeBaseSelect;
      ocp_mode_t compareModeSelect;
   } ocp_ctrl_t;

   // Pulse sequencer states
   typedef enum logic [2:0] {
      OCP_P_IDLE = 3'b001,
      OCP_P_RISE = 3'b010,
      OCP_P_FALL = 3'b100
   } ocp_pulse_t;

endpackage
